/* rtl/reset_clock_mode_decoder.sv */
/*
  Reset-time clock configuration decoder with an AHB-Lite register view.
  Assumes strap pins and the hard-reset input are asynchronous to clk_in
  and that the configuration-word high bits are held by the board during
  hard reset.
*/
// Added by the designer: the register addresses and the AHB-Lite register port.
//
// Functional notes
// (RULE1) Sample the three low strap bits while hard reset is held.
// (RULE2) In configuration-word mode four high bits extend the selector to seven.
// (RULE3) New ratios take effect only after power-on reset, not hard reset.
// (RULE4) Default codes 000-011: COMMS_PROCESSOR_CLOCK 3,3,4,4 and core 4,5,4,5.
// (RULE5) Default codes 100-111: COMMS_PROCESSOR_CLOCK 2,2,2.5,2.5 and core 2.5,3,2.5,3.
// (RULE6) High 0001 local mode: COMMS_PROCESSOR_CLOCK 2, core 4 to 8.
// (RULE7) High 1000 local mode: COMMS_PROCESSOR_CLOCK 3.5, core 3 to 4.5.
// (RULE8) Board picks input clock so core and COMMS_PROCESSOR_CLOCK stay in rated range.
// (RULE9) Mode pin high means local; else config bit picks host or agent.
// (RULE10) PCI clock-range bit low means 50-66 MHz, high means 25-50 MHz.
// (RULE11) In PCI mode range comes from line five, high bits from lines zero to three.
// (RULE12) Agent code 0100_100: COMMS_PROCESSOR_CLOCK 200 MHz, core 4.5, bus division 3.
// (RULE13) Agent high 0101: COMMS_PROCESSOR_CLOCK 5, bus division 2.5, core 2.5 to 4.5.
// (RULE14) Agent high 0110: COMMS_PROCESSOR_CLOCK 4 or 8, bus division 3, core 2.5 to 4.5.
// (RULE15) Agent high 0111: COMMS_PROCESSOR_CLOCK 3 or 6, bus division 2, core 2 to 3.5.
// (RULE16) Agent high 1000: COMMS_PROCESSOR_CLOCK 3 or 6, bus division 2.5, core 2 to 4.5.
// (RULE17) Agent high 1001: COMMS_PROCESSOR_CLOCK 4 or 8, bus division 4, core 2.5 to 4.5.
// (RULE18) Hold selector and ratios between power-on resets; flag undefined codes.
`timescale 1ns/10ps
module reset_clock_mode_decoder (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic hard_reset_in,
  input wire logic reset_config_select,
  input wire logic [2:0] clock_mode_strap_low,
  input wire logic [3:0] clock_mode_high_bits,
  input wire logic pci_mode_in,
  input wire logic pci_cfg0_in,
  input wire logic local_gp_line0,
  input wire logic local_gp_line1,
  input wire logic local_gp_line2,
  input wire logic local_gp_line3,
  input wire logic local_gp_line5,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [1:0] mode_out,
  output logic pci_slow_out,
  output logic [4:0] comms_processor_clock_x2_out,
  output logic [4:0] core_x2_out,
  output logic [3:0] busdiv_x2_out,
  output logic unsupported_out
);

  localparam int PIN_W = 14;

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s1_r;
  logic [PIN_W-1:0] pins_s2_r;
  logic hard_reset_s;
  logic cfg_sel_s;
  logic [2:0] strap_s;
  logic [3:0] cfg_high_s;
  logic pci_mode_s;
  logic pci_cfg0_s;
  logic [3:0] gp_high_s;
  logic gp_slow_s;
  clk_mode_pkg::selector_t sample_r;
  clk_mode_pkg::selector_t sample_nxt;
  clk_mode_pkg::selector_t active_r;
  clk_mode_pkg::ratio_t table_ratio;
  clk_mode_pkg::ratio_t active_ratio_r;
  logic [31:0] ctrl_r;
  logic [31:0] rdata_nxt;
  logic apply_pulse_r;
  logic wr_pend_r;
  logic [31:0] wr_addr_r;

  assign pins_raw = {hard_reset_in, reset_config_select, clock_mode_strap_low, clock_mode_high_bits,
                     pci_mode_in, pci_cfg0_in, local_gp_line5,
                     local_gp_line3, local_gp_line2};

  // Pins are asynchronous, so every one passes two flops before use.
  // The synchronisers run through power-on reset so hard reset never reads as released too early.
  always_ff @(posedge clk_in) begin
    pins_s1_r <= pins_raw;
    pins_s2_r <= pins_s1_r;
  end

  logic [1:0] gp_low_s1_r;
  logic [1:0] gp_low_s2_r;
  always_ff @(posedge clk_in) begin
    gp_low_s1_r <= {local_gp_line1, local_gp_line0};
    gp_low_s2_r <= gp_low_s1_r;
  end

  assign hard_reset_s = pins_s2_r[13];
  assign cfg_sel_s = pins_s2_r[12];
  assign strap_s = pins_s2_r[11:9];
  assign cfg_high_s = pins_s2_r[8:5];
  assign pci_mode_s = pins_s2_r[4];
  assign pci_cfg0_s = pins_s2_r[3];
  assign gp_slow_s = pins_s2_r[2];
  assign gp_high_s = {gp_low_s2_r[0], gp_low_s2_r[1], pins_s2_r[0], pins_s2_r[1]};

  always_comb begin
    sample_nxt.low_bits = strap_s; // RULE1
    sample_nxt.cfg_word = cfg_sel_s;
    if (pci_mode_s) begin
      sample_nxt.mode = clk_mode_pkg::MODE_LOCAL; // RULE9
      sample_nxt.pci_slow = 1'b0;
      sample_nxt.high_bits = cfg_sel_s ? cfg_high_s : 4'h0; // RULE2
    end else begin
      sample_nxt.mode = pci_cfg0_s ? clk_mode_pkg::MODE_AGENT : clk_mode_pkg::MODE_HOST; // RULE9
      sample_nxt.pci_slow = gp_slow_s; // RULE10 RULE11
      sample_nxt.high_bits = gp_high_s; // RULE11
    end
  end

  // Tracks the pins for as long as hard reset is held, then freezes.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sample_r <= '0;
    end else if (hard_reset_s) begin
      sample_r <= sample_nxt; // RULE1
    end
  end

  ratio_table u_table (
    .high_bits_in(sample_r.high_bits),
    .low_bits_in(sample_r.low_bits),
    .cfg_word_in(sample_r.cfg_word),
    .mode_in(sample_r.mode),
    .ratio_out(table_ratio)
  );

  // srst_in stands for power-on reset. The first cycle after it with hard reset released applies,
  // and later hard resets only refresh the sample, never the active set.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      apply_pulse_r <= 1'b1;
    end else if (apply_pulse_r && !hard_reset_s) begin
      apply_pulse_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      active_r <= '0;
      active_ratio_r <= '0;
    end else if (apply_pulse_r && !hard_reset_s) begin
      active_r <= sample_r; // RULE3
      active_ratio_r <= table_ratio; // RULE18
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mode_out <= 2'b00;
      pci_slow_out <= 1'b0;
      comms_processor_clock_x2_out <= '0;
      core_x2_out <= '0;
      busdiv_x2_out <= '0;
      unsupported_out <= 1'b0;
    end else begin
      mode_out <= active_r.mode;
      pci_slow_out <= active_r.pci_slow;
      comms_processor_clock_x2_out <= active_r.pci_slow ? active_ratio_r.cpm_slow_x2
                                                        : active_ratio_r.cpm_fast_x2;
      core_x2_out <= active_ratio_r.core_x2;
      busdiv_x2_out <= active_ratio_r.busdiv_x2;
      unsupported_out <= !apply_pulse_r && !active_ratio_r.valid; // RULE18
    end
  end

  // AHB-Lite slave: zero wait states, OKAY always.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      wr_addr_r <= haddr;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl_r <= clk_mode_pkg::CTRL_RESET;
    end else if (wr_pend_r && wr_addr_r == clk_mode_pkg::ADDR_CTRL) begin
      ctrl_r <= {31'h0000_0000, hwdata[0]};
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (haddr)
      clk_mode_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
      clk_mode_pkg::ADDR_SEL: begin
        rdata_nxt[2:0] = active_r.low_bits;
        rdata_nxt[clk_mode_pkg::SEL_HIGH_LSB +: 4] = active_r.high_bits;
        rdata_nxt[clk_mode_pkg::SEL_MODE_LSB +: 2] = active_r.mode;
        rdata_nxt[clk_mode_pkg::SEL_SLOW_BIT] = active_r.pci_slow;
        rdata_nxt[clk_mode_pkg::SEL_CFG_BIT] = active_r.cfg_word;
      end
      clk_mode_pkg::ADDR_RATIO: begin
        rdata_nxt[4:0] = active_ratio_r.cpm_fast_x2;
        rdata_nxt[clk_mode_pkg::RATIO_SLOW_LSB +: 5] = active_ratio_r.cpm_slow_x2;
        rdata_nxt[clk_mode_pkg::RATIO_CORE_LSB +: 5] = active_ratio_r.core_x2;
        rdata_nxt[clk_mode_pkg::RATIO_BUS_LSB +: 4] = active_ratio_r.busdiv_x2;
        rdata_nxt[clk_mode_pkg::RATIO_VALID_BIT] = active_ratio_r.valid;
      end
      clk_mode_pkg::ADDR_STATUS: begin
        rdata_nxt[0] = hard_reset_s;
        rdata_nxt[1] = unsupported_out;
        rdata_nxt[2] = sample_r != active_r;
        rdata_nxt[3] = ctrl_r[0] ? table_ratio.valid : 1'b0;
      end
      clk_mode_pkg::ADDR_ID: rdata_nxt = clk_mode_pkg::ID_VALUE;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= rdata_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Checks.
  // Short terms for the table spot checks below.
  logic agent_sel;
  logic ext_local_sel;
  assign agent_sel = sample_r.mode == clk_mode_pkg::MODE_AGENT;
  assign ext_local_sel = sample_r.cfg_word && sample_r.mode == clk_mode_pkg::MODE_LOCAL;
  hold_active_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE3
    !apply_pulse_r |=> $stable(active_r))
    else $error("active selector changed without power-on reset");
  hard_hold_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE1
    !hard_reset_s |=> $stable(sample_r))
    else $error("sample moved outside hard reset");
  local_mode_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE9
    hard_reset_s && pci_mode_s |=> sample_r.mode == clk_mode_pkg::MODE_LOCAL)
    else $error("mode pin high did not give local mode");
  agent_mode_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE9
    hard_reset_s && !pci_mode_s && pci_cfg0_s |=> sample_r.mode == clk_mode_pkg::MODE_AGENT)
    else $error("agent mode not decoded");
  range_bit_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE10
    hard_reset_s && !pci_mode_s |=> sample_r.pci_slow == $past(gp_slow_s))
    else $error("clock range bit not taken from line five");
  default_ratio_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE4
    !sample_r.cfg_word && sample_r.mode == clk_mode_pkg::MODE_LOCAL && sample_r.low_bits == 3'h1
      |-> table_ratio.cpm_fast_x2 == 5'h06 && table_ratio.core_x2 == 5'h0A)
    else $error("default code 001 gave wrong ratios");
  agent_bus_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE17
    sample_r.mode == clk_mode_pkg::MODE_AGENT && sample_r.high_bits == 4'h9 && sample_r.low_bits == 3'h2
      |-> table_ratio.busdiv_x2 == 4'h8 && table_ratio.core_x2 == 5'h07)
    else $error("agent code 1001_010 gave wrong ratios");
  unsup_flag_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE18
    !apply_pulse_r && !active_ratio_r.valid |=> unsupported_out)
    else $error("undefined code not flagged");
  cpm_out_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE10
    active_r.pci_slow |=> comms_processor_clock_x2_out == $past(active_ratio_r.cpm_slow_x2))
    else $error("slow clock factor not selected");

  low_take_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE1
    hard_reset_s
    |=> sample_r.low_bits == $past(strap_s))
    else $error("strap bits not taken");
  cfg_high_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE2
    hard_reset_s && pci_mode_s && cfg_sel_s
    |=> sample_r.high_bits == $past(cfg_high_s))
    else $error("word high bits not taken");
  gp_high_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE11
    hard_reset_s && !pci_mode_s
    |=> sample_r.high_bits == $past(gp_high_s))
    else $error("line high bits not taken");
  host_mode_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE9
    hard_reset_s && !pci_mode_s && !pci_cfg0_s
    |=> sample_r.mode == clk_mode_pkg::MODE_HOST)
    else $error("host mode not decoded");
  apply_once_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE3
    apply_pulse_r && !hard_reset_s
    |=> !apply_pulse_r && active_r == $past(sample_r))
    else $error("sample not applied once");
  default_hi_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE5
    !sample_r.cfg_word && sample_r.mode == clk_mode_pkg::MODE_LOCAL && sample_r.low_bits == 3'h6
    |-> table_ratio.cpm_fast_x2 == 5'h05 && table_ratio.core_x2 == 5'h05)
    else $error("default code 110 wrong");
  local_ext_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE6
    ext_local_sel && sample_r.high_bits == 4'h1 && sample_r.low_bits == 3'h4
    |-> table_ratio.cpm_fast_x2 == 5'h04 && table_ratio.core_x2 == 5'h10)
    else $error("local code 0001_100 wrong");
  local_fast_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE7
    ext_local_sel && sample_r.high_bits == 4'h8 && sample_r.low_bits == 3'h2
    |-> table_ratio.cpm_fast_x2 == 5'h07 && table_ratio.core_x2 == 5'h07)
    else $error("local code 1000_010 wrong");
  agent_top_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE12
    agent_sel && sample_r.high_bits == 4'h4 && sample_r.low_bits == 3'h4
    |-> table_ratio.cpm_slow_x2 == 5'h0C && table_ratio.core_x2 == 5'h09 && table_ratio.busdiv_x2 == 4'h6)
    else $error("agent code 0100_100 wrong");
  agent_five_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE13
    agent_sel && sample_r.high_bits == 4'h5 && sample_r.low_bits == 3'h0
    |-> table_ratio.cpm_fast_x2 == 5'h0A && table_ratio.core_x2 == 5'h05 && table_ratio.busdiv_x2 == 4'h5)
    else $error("agent code 0101_000 wrong");
  agent_six_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE14
    agent_sel && sample_r.high_bits == 4'h6 && sample_r.low_bits == 3'h0
    |-> table_ratio.cpm_slow_x2 == 5'h10 && table_ratio.core_x2 == 5'h05 && table_ratio.busdiv_x2 == 4'h6)
    else $error("agent code 0110_000 wrong");
  agent_seven_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE15
    agent_sel && sample_r.high_bits == 4'h7 && sample_r.low_bits == 3'h3
    |-> table_ratio.cpm_fast_x2 == 5'h06 && table_ratio.core_x2 == 5'h07 && table_ratio.busdiv_x2 == 4'h4)
    else $error("agent code 0111_011 wrong");
  agent_eight_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE16
    agent_sel && sample_r.high_bits == 4'h8 && sample_r.low_bits == 3'h5
    |-> table_ratio.cpm_slow_x2 == 5'h0C && table_ratio.core_x2 == 5'h09 && table_ratio.busdiv_x2 == 4'h5)
    else $error("agent code 1000_101 wrong");
  host_unsup_a: assert property (@(posedge clk_in) disable iff (srst_in) // RULE18
    sample_r.mode == clk_mode_pkg::MODE_HOST
    |-> !table_ratio.valid)
    else $error("host mode not flagged");

  apply_c: cover property (@(posedge clk_in) disable iff (srst_in) apply_pulse_r ##1 !apply_pulse_r);
  agent_c: cover property (@(posedge clk_in) disable iff (srst_in) mode_out == 2'b10);
  unsup_c: cover property (@(posedge clk_in) disable iff (srst_in) unsupported_out);
  host_c: cover property (@(posedge clk_in) disable iff (srst_in) mode_out == 2'b01);
  ext_c: cover property (@(posedge clk_in) disable iff (srst_in) active_r.cfg_word && active_ratio_r.valid);

endmodule // reset_clock_mode_decoder

/* rtl/clk_mode_pkg.sv */
/*
  Shared constants and carriers for the reset-time clock mode decoder.
  Assumes a single 10 MHz system clock and a synchronous active-high reset.
*/
package clk_mode_pkg;

  // Factors are carried in half units: a value of 7 means 3.5.
  typedef struct packed {
    logic [4:0] cpm_fast_x2;
    logic [4:0] cpm_slow_x2;
    logic [4:0] core_x2;
    logic [3:0] busdiv_x2;
    logic       valid;
  } ratio_t;

  typedef enum logic [1:0] {
    MODE_LOCAL = 2'b00,
    MODE_HOST  = 2'b01,
    MODE_AGENT = 2'b10
  } clk_mode_t;

  typedef struct packed {
    logic [3:0] high_bits;
    logic [2:0] low_bits;
    clk_mode_t  mode;
    logic       pci_slow;
    logic       cfg_word;
  } selector_t;

  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_SEL = 32'h0000_0004;
  localparam logic [31:0] ADDR_RATIO = 32'h0000_0008;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_000C;
  localparam logic [31:0] ADDR_ID = 32'h0000_0010;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ID_VALUE = 32'h0000_5A01;
  localparam int SEL_HIGH_LSB = 4;
  localparam int SEL_MODE_LSB = 8;
  localparam int SEL_SLOW_BIT = 10;
  localparam int SEL_CFG_BIT = 11;
  localparam int RATIO_SLOW_LSB = 5;
  localparam int RATIO_CORE_LSB = 10;
  localparam int RATIO_BUS_LSB = 15;
  localparam int RATIO_VALID_BIT = 19;

endpackage

/* rtl/ratio_table.sv */
/*
  Combinational lookup from the seven-bit mode selector to clock factors.
  Assumes its inputs are already stable, latched copies.
*/
`timescale 1ns/10ps
module ratio_table (
  input wire logic [3:0] high_bits_in,
  input wire logic [2:0] low_bits_in,
  input wire logic cfg_word_in,
  input wire clk_mode_pkg::clk_mode_t mode_in,
  output clk_mode_pkg::ratio_t ratio_out
);

  always_comb begin
    ratio_out = '0;
    if (!cfg_word_in && mode_in == clk_mode_pkg::MODE_LOCAL) begin
      ratio_out.valid = 1'b1;
      ratio_out.busdiv_x2 = 4'h2;
      // Low half assumes a 33 MHz input, upper half 66 MHz.
      if (!low_bits_in[2]) begin
        ratio_out.cpm_fast_x2 = low_bits_in[1] ? 5'h08 : 5'h06; // RULE4
        ratio_out.core_x2 = low_bits_in[0] ? 5'h0A : 5'h08; // RULE4
      end else begin
        ratio_out.cpm_fast_x2 = low_bits_in[1] ? 5'h05 : 5'h04; // RULE5
        ratio_out.core_x2 = low_bits_in[0] ? 5'h06 : 5'h05; // RULE5
      end
      ratio_out.cpm_slow_x2 = ratio_out.cpm_fast_x2;
    end else if (mode_in == clk_mode_pkg::MODE_LOCAL) begin
      if (high_bits_in == 4'h1 && low_bits_in <= 3'h4) begin
        ratio_out.valid = 1'b1; // RULE6
        ratio_out.cpm_fast_x2 = 5'h04;
        ratio_out.core_x2 = 5'(5'h08 + {low_bits_in, 1'b0});
      end else if (high_bits_in == 4'h8 && low_bits_in >= 3'h1 && low_bits_in <= 3'h4) begin
        ratio_out.valid = 1'b1; // RULE7
        ratio_out.cpm_fast_x2 = 5'h07;
        ratio_out.core_x2 = 5'(5'h05 + low_bits_in);
      end
      ratio_out.cpm_slow_x2 = ratio_out.cpm_fast_x2;
      ratio_out.busdiv_x2 = ratio_out.valid ? 4'h2 : 4'h0;
    end else if (mode_in == clk_mode_pkg::MODE_AGENT) begin
      unique case (high_bits_in)
        4'h4: if (low_bits_in == 3'h4) begin
          ratio_out = '{5'h06, 5'h0C, 5'h09, 4'h6, 1'b1}; // RULE12
        end
        4'h5: if (low_bits_in <= 3'h4) begin
          ratio_out = '{5'h0A, 5'h0A, 5'(5'h05 + low_bits_in), 4'h5, 1'b1}; // RULE13
        end
        4'h6: if (low_bits_in <= 3'h4) begin
          ratio_out = '{5'h08, 5'h10, 5'(5'h05 + low_bits_in), 4'h6, 1'b1}; // RULE14
        end
        4'h7: if (low_bits_in <= 3'h3) begin
          ratio_out = '{5'h06, 5'h0C, 5'(5'h04 + low_bits_in), 4'h4, 1'b1}; // RULE15
        end
        4'h8: if (low_bits_in <= 3'h5) begin
          ratio_out = '{5'h06, 5'h0C, 5'(5'h04 + low_bits_in), 4'h5, 1'b1}; // RULE16
        end
        4'h9: if (low_bits_in <= 3'h4) begin
          ratio_out = '{5'h08, 5'h10, 5'(5'h05 + low_bits_in), 4'h8, 1'b1}; // RULE17
        end
        default: ratio_out = '0; // RULE18
      endcase
    end
  end

endmodule // ratio_table

/* verif/strap_board.sv */
/*
  Board-side model of the reset strap pins and the configuration-word source.
  Assumes the bench raises hold_in to keep hard reset asserted and changes sel_in only while it is held.
*/
`timescale 1ns/10ps
module strap_board (
  input wire logic clk_in,
  input wire logic hold_in,
  input wire clk_mode_pkg::selector_t sel_in,
  output logic hard_reset_out,
  output logic reset_config_out,
  output logic [2:0] strap_low_out,
  output logic [3:0] high_bits_out,
  output logic pci_mode_out,
  output logic pci_cfg0_out,
  output logic [3:0] gp_high_out,
  output logic gp5_out
);
  logic [2:0] since_r;
  logic live;
  logic pci;

  always_ff @(posedge clk_in) begin
    if (hold_in) begin
      since_r <= 3'h0;
    end else if (since_r != 3'h7) begin
      since_r <= since_r + 3'h1;
    end
  end

  // Once the hold time after release has run out the board stops driving, so the lines show inverted values.
  assign live = hold_in || (since_r < 3'h4);
  assign pci = (sel_in.mode != clk_mode_pkg::MODE_LOCAL);

  always_comb begin
    hard_reset_out = hold_in;
    reset_config_out = sel_in.cfg_word;
    pci_mode_out = !pci;
    pci_cfg0_out = (sel_in.mode == clk_mode_pkg::MODE_AGENT);
    strap_low_out = live ? sel_in.low_bits : ~sel_in.low_bits;
    high_bits_out = (live && !pci) ? sel_in.high_bits : ~sel_in.high_bits;
    gp_high_out = (live && pci) ? sel_in.high_bits : ~sel_in.high_bits;
    gp5_out = (live && pci) ? sel_in.pci_slow : ~sel_in.pci_slow;
  end
endmodule // strap_board

/* verif/tb_top.sv */
/*
  Self-checking bench for the reset clock mode decoder: strap cases through the board model, registers over AHB-Lite.
  Assumes the design answers with zero wait states and that hready is fed from hreadyout.
*/
`timescale 1ns/10ps
module tb_top;
  logic clk_in = 1'b0;
  logic srst_in;
  logic hold;
  clk_mode_pkg::selector_t sel;
  logic hr_w, rcs_w, pmode_w, cfg0_w, gp5_w;
  logic [2:0] low_w;
  logic [3:0] high_w, gp_w;
  logic hsel, hwrite, hreadyout, hresp, pci_slow_out, unsupported_out;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, mode_out;
  logic [2:0] hsize;
  logic [4:0] cpm_x2, core_x2;
  logic [3:0] busdiv_x2;
  int n_mismatch = 0;
  int num_checks = 0;

  always #50 clk_in = ~clk_in;

  strap_board board (.clk_in(clk_in), .hold_in(hold), .sel_in(sel), .hard_reset_out(hr_w),
    .reset_config_out(rcs_w), .strap_low_out(low_w), .high_bits_out(high_w), .pci_mode_out(pmode_w),
    .pci_cfg0_out(cfg0_w), .gp_high_out(gp_w), .gp5_out(gp5_w));

  reset_clock_mode_decoder DUT (.clk_in(clk_in), .srst_in(srst_in), .hard_reset_in(hr_w),
    .reset_config_select(rcs_w), .clock_mode_strap_low(low_w), .clock_mode_high_bits(high_w),
    .pci_mode_in(pmode_w), .pci_cfg0_in(cfg0_w), .local_gp_line0(gp_w[3]), .local_gp_line1(gp_w[2]),
    .local_gp_line2(gp_w[1]), .local_gp_line3(gp_w[0]), .local_gp_line5(gp5_w), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mode_out(mode_out), .pci_slow_out(pci_slow_out),
    .comms_processor_clock_x2_out(cpm_x2), .core_x2_out(core_x2), .busdiv_x2_out(busdiv_x2),
    .unsupported_out(unsupported_out));

  task automatic test_done;
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  function automatic clk_mode_pkg::selector_t mk(input logic [1:0] m, input logic c, input logic [3:0] h,
      input logic [2:0] l, input logic sl);
    return clk_mode_pkg::selector_t'({h, l, m, sl, c});
  endfunction

  // Packs {unsupported, bus x2, core x2, cpm x2}; factors are in half units.
  function automatic logic [14:0] expect_of(input clk_mode_pkg::selector_t s);
    logic [4:0] fast, slow, base, step, core;
    logic [2:0] lo, hi;
    logic [3:0] bus;
    logic bad;
    bad = 1'b0;
    {fast, slow, base, step, lo, hi, bus} = {5'h0, 5'h0, 5'h0, 5'h1, 3'h0, 3'h0, 4'h2};
    if (s.mode == clk_mode_pkg::MODE_LOCAL && !s.cfg_word) begin
      fast = s.low_bits[2] ? (s.low_bits[1] ? 5'h5 : 5'h4) : (s.low_bits[1] ? 5'h8 : 5'h6);
      core = s.low_bits[2] ? (s.low_bits[0] ? 5'h6 : 5'h5) : (s.low_bits[0] ? 5'hA : 5'h8);
      return {1'b0, bus, core, fast};
    end
    case ({s.mode, s.high_bits})
      6'h01: {fast, slow, base, step, lo, hi, bus} = {5'h4, 5'h4, 5'h8, 5'h2, 3'h0, 3'h4, 4'h2};
      6'h08: {fast, slow, base, step, lo, hi, bus} = {5'h7, 5'h7, 5'h5, 5'h1, 3'h1, 3'h4, 4'h2};
      6'h24: {fast, slow, base, step, lo, hi, bus} = {5'h6, 5'hC, 5'h5, 5'h1, 3'h4, 3'h4, 4'h6};
      6'h25: {fast, slow, base, step, lo, hi, bus} = {5'hA, 5'hA, 5'h5, 5'h1, 3'h0, 3'h4, 4'h5};
      6'h26: {fast, slow, base, step, lo, hi, bus} = {5'h8, 5'h10, 5'h5, 5'h1, 3'h0, 3'h4, 4'h6};
      6'h27: {fast, slow, base, step, lo, hi, bus} = {5'h6, 5'hC, 5'h4, 5'h1, 3'h0, 3'h3, 4'h4};
      6'h28: {fast, slow, base, step, lo, hi, bus} = {5'h6, 5'hC, 5'h4, 5'h1, 3'h0, 3'h5, 4'h5};
      6'h29: {fast, slow, base, step, lo, hi, bus} = {5'h8, 5'h10, 5'h5, 5'h1, 3'h0, 3'h4, 4'h8};
      default: bad = 1'b1;
    endcase
    bad = bad || (s.low_bits < lo) || (s.low_bits > hi);
    core = base + step * {2'h0, s.low_bits};
    return {bad, bus, core, s.pci_slow ? slow : fast};
  endfunction

  // Power-on reset is given while hard reset is held, so the new straps become the active configuration.
  task automatic run_case(input clk_mode_pkg::selector_t s);
    logic [14:0] e;
    e = expect_of(s);
    sel <= s;
    hold <= 1'b1;
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    hold <= 1'b0;
    repeat (10) @(posedge clk_in);
    check({31'h0, unsupported_out}, {31'h0, e[14]});
    check({30'h0, mode_out}, {30'h0, s.mode});
    if (s.mode != clk_mode_pkg::MODE_LOCAL) check({31'h0, pci_slow_out}, {31'h0, s.pci_slow});
    if (!e[14]) begin
      check({27'h0, cpm_x2}, {27'h0, e[4:0]});
      check({27'h0, core_x2}, {27'h0, e[9:5]});
      check({28'h0, busdiv_x2}, {28'h0, e[13:10]});
    end
  endtask

  initial begin
    srst_in = 1'b1;
    hold = 1'b1;
    sel = mk(2'h0, 1'b0, 4'h0, 3'h0, 1'b0);
    {hsel, hwrite, haddr, hwdata, htrans, hsize} = {2'h0, 32'h0, 32'h0, 2'h0, 3'h2};
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    for (int l = 0; l < 8; l++) run_case(mk(2'h0, 1'b0, 4'h0, l[2:0], 1'b0));
    for (int l = 0; l < 5; l++) begin
      run_case(mk(2'h0, 1'b1, 4'h1, l[2:0], 1'b0));
      run_case(mk(2'h0, 1'b1, 4'h8, l[2:0], 1'b0));
    end
    run_case(mk(2'h0, 1'b1, 4'h3, 3'h0, 1'b0));
    run_case(mk(2'h1, 1'b1, 4'h6, 3'h1, 1'b1));
    for (int h = 4; h < 10; h++) begin
      for (int l = 0; l < 6; l++) run_case(mk(2'h2, 1'b1, h[3:0], l[2:0], l[0]));
    end
    run_case(mk(2'h2, 1'b1, 4'h6, 3'h2, 1'b1));
    ahb(1'b0, clk_mode_pkg::ADDR_SEL, 32'h0, rd);
    check(rd & 32'h0000_07FF, 32'h0000_0662);
    ahb(1'b0, clk_mode_pkg::ADDR_RATIO, 32'h0, rd);
    check(rd & 32'h000F_FFFF, 32'h000B_1E08);
    // A hard reset alone with other straps must leave the active ratios untouched.
    sel <= mk(2'h0, 1'b0, 4'h0, 3'h0, 1'b0);
    hold <= 1'b1;
    repeat (8) @(posedge clk_in);
    hold <= 1'b0;
    repeat (12) @(posedge clk_in);
    check({27'h0, core_x2}, 32'h0000_0007);
    check({30'h0, mode_out}, 32'h0000_0002);
    ahb(1'b0, clk_mode_pkg::ADDR_ID, 32'h0, rd);
    check(rd, clk_mode_pkg::ID_VALUE);
    ahb(1'b0, clk_mode_pkg::ADDR_CTRL, 32'h0, rd);
    check(rd, clk_mode_pkg::CTRL_RESET);
    ahb(1'b1, clk_mode_pkg::ADDR_CTRL, 32'h0000_0001, rd);
    ahb(1'b0, clk_mode_pkg::ADDR_CTRL, 32'h0, rd);
    check(rd & 32'h0000_0001, 32'h0000_0001);
    ahb(1'b0, clk_mode_pkg::ADDR_STATUS, 32'h0, rd);
    check(rd, 32'h0000_000C);
    ahb(1'b1, 32'h0000_0020, 32'hFFFF_FFFF, rd);
    ahb(1'b0, 32'h0000_0020, 32'h0, rd);
    check(rd, 32'h0000_0000);
    check({31'h0, hresp}, 32'h0000_0000);
    test_done();
  end

  initial begin
    #2000000;
    n_mismatch++;
    test_done();
  end
endmodule // tb_top
